// ===== src/mpc_mode_checker.sv
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module mpc_mode_checker (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        degraded_state,
  input  wire logic        is_test_unit_ready,
  input  wire logic        is_media_access,
  input  wire logic        queue_wait_over,
  input  wire logic        post_error_enable,
  input  wire logic [6:0]  bits_in_error,
  input  wire logic        recovered_error,
  output logic             report_degraded,
  output logic             fifo_order_force,
  output logic             report_recovered,
  output logic             cmd_aborted,
  output logic             format_certify,
  output logic [7:0]       thermal_threshold,
  output logic [15:0]      aging_limit
);
  import mpc_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] sel_count;
    logic [23:0] sel_len;
    logic [7:0]  hdr;
    logic [7:0]  hdr_len;
    logic [31:0] capacity;
    logic [31:0] cur_count;
    logic [23:0] cur_len;
    logic        degr_dis;
    logic        aging_en;
    logic        certify;
    logic        injection;
    logic [11:0] exec_timer;
    logic [15:0] aging_lim;
    logic [7:0]  temp_thr;
    logic [6:0]  rpt_thr;
    logic [31:0] ignored;
    logic        chk_cond;
    logic        abort_flag;
    mpc_state_e  state;
    logic [23:0] tick_cnt;
    logic [11:0] units;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rep_degr;
    logic        fifo_force;
    logic        rep_rec;
    logic        aborted;
    logic [7:0]  thermal;
  } mpc_state_s;

  mpc_state_s s_q;
  mpc_state_s s_d;

  // ==========================================================================
  // Checks
  logic       count_ok;
  logic       len_ok;
  logic       page_ok;
  logic       savable;
  logic [7:0] exp_len;
  logic [5:0] pcode;
  logic       thr_ok;
  logic       wr_en;
  logic       rd_en;
  logic [6:0] wr_thr;

  always_comb begin
    pcode = s_q.hdr[5:0];
    // Supported pages and their lengths
    page_ok = 1'b1;
    unique case (pcode)
      6'h00: exp_len = PGLEN_00;
      6'h01: exp_len = PGLEN_01;
      6'h02: exp_len = PGLEN_02;
      6'h03: exp_len = PGLEN_03;
      6'h04: exp_len = PGLEN_04;
      6'h07: exp_len = PGLEN_07;
      6'h08: exp_len = PGLEN_08;
      6'h0A: exp_len = PGLEN_0A;
      6'h0C: exp_len = PGLEN_0C;
      6'h19: exp_len = PGLEN_19;
      6'h1A: exp_len = PGLEN_1A;
      6'h1C: exp_len = PGLEN_1C;
      default: begin
        exp_len = 8'h00;
        page_ok = 1'b0;
      end
    endcase
    savable = page_ok && (pcode != PG_FMT) && (pcode != PG_RIGID);
    count_ok = (s_q.sel_count == BD_COUNT_KEEP) || (s_q.sel_count == BD_COUNT_ALL)
             || (s_q.sel_count <= s_q.capacity);
    len_ok = (s_q.sel_len == BLK_LEN_KEEP)
           || ((s_q.sel_len >= BLK_LEN_MIN) && (s_q.sel_len <= BLK_LEN_MAX)
               && (s_q.sel_len[2:0] & BLK_LEN_STEP_M) == 3'h0);
    // Report threshold sits above the temperature byte
    wr_thr = pwdata[14:8];
    thr_ok = (wr_thr >= RPT_THR_MIN) && (wr_thr <= RPT_THR_MAX);
  end

  assign wr_en = psel && penable && pwrite && s_q.pready;
  assign rd_en = psel && penable && !pwrite && s_q.pready;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pready = psel && !penable;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;

    if (psel && !penable) begin
      unique case (paddr)
        ADDR_BD_COUNT:    s_d.prdata = s_q.sel_count;
        ADDR_BD_LEN:      s_d.prdata = {s_q.sel_len, DENSITY_CODE};
        ADDR_PAGE_HDR:    s_d.prdata = {15'h0000, page_ok, exp_len, savable, s_q.hdr[6:0]};
        ADDR_VEND_CTRL:   s_d.prdata = {28'h000_0000, s_q.injection, s_q.certify,
                                        s_q.aging_en, s_q.degr_dis};
        ADDR_VEND_TIMERS: s_d.prdata = {4'h0, s_q.exec_timer, s_q.aging_lim};
        ADDR_VEND_THRESH: s_d.prdata = {17'h0_0000, s_q.rpt_thr, s_q.temp_thr};
        ADDR_VEND_IGN:    s_d.prdata = s_q.ignored;
        ADDR_STATUS:      s_d.prdata = {29'h0000_0000, s_q.state == MPC_TIMING,
                                        s_q.abort_flag, s_q.chk_cond};
        // Exact count, density zero, user bytes per sector
        ADDR_CUR_FMT:     s_d.prdata = {s_q.cur_len, DENSITY_CODE};
        ADDR_CAPACITY:    s_d.prdata = s_q.cur_count;
        ADDR_CMD, ADDR_EVENT: s_d.prdata = 32'h0000_0000;
        default:          s_d.pslverr = 1'b1;
      endcase
      if (pwrite && paddr == ADDR_CUR_FMT) begin
        s_d.pslverr = 1'b1;
      end
    end

    if (wr_en) begin
      unique case (paddr)
        ADDR_BD_COUNT: s_d.sel_count = pwdata;
        ADDR_BD_LEN:   s_d.sel_len = pwdata[31:8];
        // Subpage flag kept in header bit 6
        ADDR_PAGE_HDR: begin
          s_d.hdr = pwdata[7:0];
          s_d.hdr_len = pwdata[15:8];
        end
        ADDR_VEND_CTRL: begin
          s_d.degr_dis = pwdata[0];
          s_d.aging_en = pwdata[1];
          s_d.certify = pwdata[2];
        end
        ADDR_VEND_TIMERS: begin
          s_d.aging_lim = pwdata[15:0];
          s_d.exec_timer = pwdata[27:16];
        end
        ADDR_VEND_THRESH: begin
          s_d.temp_thr = pwdata[7:0];
          if (thr_ok) begin
            s_d.rpt_thr = wr_thr;
          end else begin
            s_d.chk_cond = 1'b1;
          end
        end
        ADDR_VEND_IGN: s_d.ignored = pwdata;
        ADDR_CMD: begin
          if (pwdata[CMD_SELECT]) begin
            s_d.chk_cond = !count_ok || !len_ok || !page_ok || s_q.hdr[7]
                         || (s_q.hdr_len != exp_len);
          end
          if (pwdata[CMD_FORMAT]) begin
            if (s_q.sel_len != BLK_LEN_KEEP && s_q.sel_len != s_q.cur_len && len_ok) begin
              s_d.cur_len = s_q.sel_len;
            end
            if (s_q.sel_count != BD_COUNT_KEEP && s_q.sel_count != BD_COUNT_ALL
                && count_ok) begin
              s_d.cur_count = s_q.sel_count;
            end else if (s_q.sel_count == BD_COUNT_ALL) begin
              s_d.cur_count = s_q.capacity;
            end
            s_d.injection = pwdata[4];
          end
        end
        // Clear sticky flags, write one to clear
        ADDR_EVENT: begin
          if (pwdata[0]) s_d.chk_cond = 1'b0;
          if (pwdata[1]) s_d.abort_flag = 1'b0;
        end
        default: ;
      endcase
    end

    // ==========================================================================
    // Command execution timer
    // Timer, separate from aging
    unique case (s_q.state)
      MPC_IDLE: begin
        if (wr_en && paddr == ADDR_CMD && pwdata[CMD_START] && s_q.exec_timer != 12'h000) begin
          s_d.state = MPC_TIMING;
          s_d.tick_cnt = 24'h00_0000;
          s_d.units = 12'h000;
        end
      end
      MPC_TIMING: begin
        if (wr_en && paddr == ADDR_CMD && pwdata[CMD_DONE]) begin
          s_d.state = MPC_IDLE;
        end else if (s_q.tick_cnt == TICK_CNT_MAX) begin
          s_d.tick_cnt = 24'h00_0000;
          s_d.units = s_q.units + 12'h001;
          if (s_q.units + 12'h001 >= s_q.exec_timer) begin
            s_d.state = MPC_ABORT;
          end
        end else begin
          s_d.tick_cnt = s_q.tick_cnt + 24'h00_0001;
        end
      end
      MPC_ABORT: begin
        // Set wins over a same-cycle clear
        s_d.abort_flag = 1'b1;
        s_d.state = MPC_IDLE;
      end
      default: s_d.state = MPC_IDLE;
    endcase
    s_d.aborted = (s_q.state == MPC_ABORT);

    s_d.rep_degr = degraded_state && (is_media_access || (is_test_unit_ready && !s_q.degr_dis));
    s_d.fifo_force = s_q.aging_en && queue_wait_over;
    s_d.rep_rec = recovered_error && post_error_enable && (bits_in_error > s_q.rpt_thr);
    // Zero picks default threshold
    // Taken from the next value so the output moves with the stored field
    s_d.thermal = (s_d.temp_thr == 8'h00) ? TEMP_THR_DEF : s_d.temp_thr;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.capacity <= CAPACITY_DEF;
      s_q.cur_count <= CAPACITY_DEF;
      s_q.cur_len <= BLK_LEN_DEF;
      s_q.degr_dis <= DEGR_DIS_RST;
      s_q.aging_en <= AGING_EN_RST;
      s_q.exec_timer <= EXEC_TIMER_RST;
      s_q.aging_lim <= AGING_LIMIT_RST;
      s_q.temp_thr <= TEMP_THR_RST;
      s_q.rpt_thr <= RPT_THR_RST;
      s_q.thermal <= TEMP_THR_DEF;
      s_q.state <= MPC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign report_degraded = s_q.rep_degr;
  assign fifo_order_force = s_q.fifo_force;
  assign report_recovered = s_q.rep_rec;
  assign cmd_aborted = s_q.aborted;
  assign format_certify = s_q.certify;
  assign thermal_threshold = s_q.thermal;
  assign aging_limit = s_q.aging_lim;
endmodule : mpc_mode_checker

// ===== src/mpc_pkg.sv
package mpc_pkg;
  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [11:0] ADDR_BD_COUNT    = 12'h000;
  localparam logic [11:0] ADDR_BD_LEN      = 12'h004;
  localparam logic [11:0] ADDR_PAGE_HDR    = 12'h008;
  localparam logic [11:0] ADDR_VEND_CTRL   = 12'h00C;
  localparam logic [11:0] ADDR_VEND_TIMERS = 12'h010;
  localparam logic [11:0] ADDR_VEND_THRESH = 12'h014;
  localparam logic [11:0] ADDR_VEND_IGN    = 12'h018;
  localparam logic [11:0] ADDR_CMD         = 12'h01C;
  localparam logic [11:0] ADDR_STATUS      = 12'h020;
  localparam logic [11:0] ADDR_CUR_FMT     = 12'h024;
  localparam logic [11:0] ADDR_EVENT       = 12'h028;
  localparam logic [11:0] ADDR_CAPACITY    = 12'h02C;

  // ==========================================================================
  // Block descriptor values
  localparam logic [31:0] BD_COUNT_KEEP  = 32'h0000_0000;
  localparam logic [31:0] BD_COUNT_ALL   = 32'hFFFF_FFFF;
  localparam logic [23:0] BLK_LEN_KEEP   = 24'h00_0000;
  localparam logic [23:0] BLK_LEN_MIN    = 24'h00_0200;
  localparam logic [23:0] BLK_LEN_MAX    = 24'h00_0210;
  localparam logic [2:0]  BLK_LEN_STEP_M = 3'h7;
  localparam logic [7:0]  DENSITY_CODE   = 8'h00;
  localparam logic [31:0] CAPACITY_DEF   = 32'h0100_0000;
  localparam logic [23:0] BLK_LEN_DEF    = 24'h00_0200;

  // ==========================================================================
  // Page codes and lengths
  localparam logic [5:0] PG_VENDOR = 6'h00;
  localparam logic [5:0] PG_FMT    = 6'h03;
  localparam logic [5:0] PG_RIGID  = 6'h04;
  localparam logic [7:0] PGLEN_00 = 8'h0E;
  localparam logic [7:0] PGLEN_01 = 8'h0A;
  localparam logic [7:0] PGLEN_02 = 8'h0E;
  localparam logic [7:0] PGLEN_03 = 8'h16;
  localparam logic [7:0] PGLEN_04 = 8'h16;
  localparam logic [7:0] PGLEN_07 = 8'h0A;
  localparam logic [7:0] PGLEN_08 = 8'h12;
  localparam logic [7:0] PGLEN_0A = 8'h0A;
  localparam logic [7:0] PGLEN_0C = 8'h16;
  localparam logic [7:0] PGLEN_19 = 8'h06;
  localparam logic [7:0] PGLEN_1A = 8'h0A;
  localparam logic [7:0] PGLEN_1C = 8'h0A;

  // ==========================================================================
  // Vendor page reset values, defaults and limits
  localparam logic [15:0] AGING_LIMIT_RST = 16'h0030;
  localparam logic [11:0] EXEC_TIMER_RST  = 12'h000;
  localparam logic [7:0]  TEMP_THR_RST    = 8'h00;
  localparam logic [7:0]  TEMP_THR_DEF    = 8'h46;
  localparam logic [6:0]  RPT_THR_RST     = 7'h03;
  localparam logic [6:0]  RPT_THR_MIN     = 7'h03;
  localparam logic [6:0]  RPT_THR_MAX     = 7'h17;
  localparam logic        DEGR_DIS_RST    = 1'b0;
  localparam logic        AGING_EN_RST    = 1'b1;

  // ==========================================================================
  // Timing
  localparam int          CLK_MHZ      = 250;
  localparam int          TICK_MS      = 50;
  localparam int          TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
  localparam logic [23:0] TICK_CNT_MAX = 24'(TICK_CYCLES - 1);

  // Command register bits
  localparam int CMD_SELECT = 0;
  localparam int CMD_FORMAT = 1;
  localparam int CMD_START  = 2;
  localparam int CMD_DONE   = 3;

  typedef enum logic [1:0] {
    MPC_IDLE   = 2'b00,
    MPC_TIMING = 2'b01,
    MPC_ABORT  = 2'b10
  } mpc_state_e;
endpackage : mpc_pkg

// ===== verification/mode_parameter_checker_test.sv
`timescale 1ns/1ps
module mode_parameter_checker_test;
  import mpc_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic        e;
    logic [31:0] m;
    logic [31:0] v;
  } mpc_exp_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic degraded_state, is_test_unit_ready, is_media_access, queue_wait_over;
  logic post_error_enable, recovered_error, report_degraded, fifo_order_force;
  logic report_recovered, cmd_aborted, format_certify;
  logic [6:0] bits_in_error;
  logic [7:0] thermal_threshold;
  logic [15:0] aging_limit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] rnd = 16'hFA71;
  mpc_exp_s q[$];
  int err_count = 0;
  int checks = 0;
  logic [31:0] cnt[5] = '{BD_COUNT_KEEP, BD_COUNT_ALL, CAPACITY_DEF, CAPACITY_DEF - 1,
                          CAPACITY_DEF + 1};
  logic [23:0] lens[7] = '{24'h0, 24'h200, 24'h208, 24'h210, 24'h218, 24'h1FF, 24'h204};
  logic [5:0] pg[12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h08, 6'h0A, 6'h0C,
                         6'h19, 6'h1A, 6'h1C};
  logic [7:0] pl[12] = '{PGLEN_00, PGLEN_01, PGLEN_02, PGLEN_03, PGLEN_04, PGLEN_07,
                         PGLEN_08, PGLEN_0A, PGLEN_0C, PGLEN_19, PGLEN_1A, PGLEN_1C};
  mpc_mode_checker i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .degraded_state, .is_test_unit_ready, .is_media_access,
    .queue_wait_over, .post_error_enable, .bits_in_error, .recovered_error, .report_degraded,
    .fifo_order_force, .report_recovered, .cmd_aborted, .format_certify, .thermal_threshold,
    .aging_limit);
  mpc_host_model i_host (.clk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // Checking and closing
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    mpc_exp_s x;
    if (rst_n && psel && penable && pready) begin
      x = q.pop_front();
      check("prdata", prdata & x.m, x.v);
      check("pslverr", {31'h0, pslverr}, {31'h0, x.e});
    end
  end
  // ==========================================================
  // Bus tasks: note the expectation, then run the transfer
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] v, input logic e);
    logic to;
    q.push_back(mpc_exp_s'{a, e, m, v & m});
    i_host.xfer(w, a, d, int'(rnd[1:0]), to);
    rnd = lfsr(rnd);
    if (to) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    acc(1'b0, a, 32'h0, m, v, 1'b0);
  endtask
  task automatic sel(input logic [11:0] a, input logic [31:0] d, input logic chk);
    wr(ADDR_EVENT, 32'h3);
    wr(a, d);
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_STATUS, 32'h1, {31'h0, chk});
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    stop_test();
  end
  initial begin
    logic [31:0] v;
    rst_n = 1'b0;
    {degraded_state, is_test_unit_ready, is_media_access} = 3'h0;
    {queue_wait_over, post_error_enable, recovered_error} = 3'h0;
    bits_in_error = 7'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CUR_FMT, 32'hFFFF_FFFF, {BLK_LEN_DEF, DENSITY_CODE});
    rd(ADDR_BD_LEN, 32'hFF, {24'h00_0000, DENSITY_CODE});
    rd(ADDR_CAPACITY, 32'hFFFF_FFFF, CAPACITY_DEF);
    rd(ADDR_VEND_TIMERS, 32'h0FFF_FFFF, 32'h30);
    rd(ADDR_VEND_THRESH, 32'h7FFF, 32'h0300);
    rd(ADDR_VEND_IGN, 32'hFFFF_FFFF, 32'h0);
    v = {rnd, ~rnd};
    wr(ADDR_VEND_IGN, v);
    rd(ADDR_VEND_IGN, 32'hFFFF_FFFF, v);
    wr(ADDR_VEND_CTRL, 32'hA);
    rd(ADDR_VEND_CTRL, 32'hF, 32'h2);
    // Refused: unmapped place and read-only format word
    acc(1'b0, 12'hFFC, 32'h0, 32'h0, 32'h0, 1'b1);
    acc(1'b1, ADDR_CUR_FMT, 32'h0, 32'h0, 32'h0, 1'b1);
    wr(ADDR_PAGE_HDR, i_host.hdr(PG_VENDOR, PGLEN_00));
    foreach (cnt[i]) sel(ADDR_BD_COUNT, cnt[i], i == 4);
    wr(ADDR_BD_COUNT, BD_COUNT_KEEP);
    foreach (lens[i]) sel(ADDR_BD_LEN, {lens[i], 8'h00}, i > 3);
    wr(ADDR_BD_LEN, {BLK_LEN_DEF, 8'h00});
    foreach (pg[i]) begin
      sel(ADDR_PAGE_HDR, i_host.hdr(pg[i], pl[i]), 1'b0);
      rd(ADDR_PAGE_HDR, 32'h1FF80, {15'h0, 1'b1, pl[i], (pg[i] != 6'h03 && pg[i] != 6'h04),
         7'h0});
    end
    sel(ADDR_PAGE_HDR, i_host.hdr(PG_VENDOR, PGLEN_00 + 8'h01), 1'b1);
    sel(ADDR_PAGE_HDR, i_host.hdr(PG_VENDOR, PGLEN_00) | 32'h80, 1'b1);
    wr(ADDR_PAGE_HDR, i_host.hdr(6'h05, 8'h0A));
    rd(ADDR_PAGE_HDR, 32'h10000, 32'h0);
    wr(ADDR_PAGE_HDR, i_host.hdr(PG_VENDOR, PGLEN_00));
    wr(ADDR_BD_LEN, {24'h208, 8'h00});
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_CUR_FMT, 32'hFFFF_FF00, {BLK_LEN_DEF, 8'h00});
    wr(ADDR_CMD, 32'h12);
    rd(ADDR_CUR_FMT, 32'hFFFF_FF00, {24'h208, 8'h00});
    rd(ADDR_VEND_CTRL, 32'h8, 32'h8);
    wr(ADDR_VEND_THRESH, 32'h0A50);
    // A select command would recompute the flag, so none follows here
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_EVENT, 32'h3);
      wr(ADDR_VEND_THRESH, i ? 32'h0250 : 32'h1850);
      rd(ADDR_STATUS, 32'h1, 32'h1);
    end
    rd(ADDR_VEND_THRESH, 32'h7F00, 32'h0A00);
    wr(ADDR_CMD, 32'h4);
    repeat (20) @(posedge clk);
    rd(ADDR_STATUS, 32'h6, 32'h0);
    wr(ADDR_VEND_TIMERS, 32'h0001_0030);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_STATUS, 32'h6, 32'h4);
    wr(ADDR_CMD, 32'h8);
    rd(ADDR_STATUS, 32'h4, 32'h0);
    // random traffic, judged by the checker
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      {degraded_state, is_test_unit_ready, is_media_access} <= rnd[2:0];
      {queue_wait_over, post_error_enable, recovered_error} <= rnd[5:3];
      bits_in_error <= {2'b00, rnd[12:8]};
      rnd = lfsr(rnd);
      if (i % 50 == 0) begin
        wr(ADDR_VEND_CTRL, {29'h0, rnd[2:0]});
        wr(ADDR_VEND_TIMERS, {16'h0, rnd});
        wr(ADDR_VEND_THRESH, {17'h0, 7'(rnd[3:0]) + 7'h03, rnd[15] ? rnd[11:4] : 8'h00});
      end
    end
    repeat (5) @(posedge clk);
    stop_test();
  end
endmodule // mode_parameter_checker_test
bind mpc_mode_checker mpc_mode_checker_asserts i_chk (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .degraded_state, .is_test_unit_ready,
  .is_media_access, .queue_wait_over, .post_error_enable, .bits_in_error, .recovered_error,
  .report_degraded, .fifo_order_force, .report_recovered, .cmd_aborted, .format_certify,
  .thermal_threshold, .aging_limit);

// ===== verification/mpc_host_model.sv
`timescale 1ns/1ps
module mpc_host_model (
  input  wire logic        clk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // header sent savable zero, short form
  function automatic logic [31:0] hdr(input logic [5:0] pg, input logic [7:0] len);
    return {16'h0, len, 2'b00, pg};
  endfunction
  // Idle gap lets the host be prompt or slow
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input int gap,
                      output logic to);
    int n;
    n = 0;
    // At least one idle edge, so no signal is driven twice in one step
    repeat (gap + 1) @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready && n < 50) begin
      @(posedge clk);
      n++;
    end
    to = !pready;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // mpc_host_model

// ===== verification/mpc_mode_checker_asserts.sv
`timescale 1ns/1ps
module mpc_mode_checker_asserts
  import mpc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        degraded_state,
  input wire logic        is_test_unit_ready,
  input wire logic        is_media_access,
  input wire logic        queue_wait_over,
  input wire logic        post_error_enable,
  input wire logic [6:0]  bits_in_error,
  input wire logic        recovered_error,
  input wire logic        report_degraded,
  input wire logic        fifo_order_force,
  input wire logic        report_recovered,
  input wire logic        cmd_aborted,
  input wire logic        format_certify,
  input wire logic [7:0]  thermal_threshold,
  input wire logic [15:0] aging_limit
);
  // ==========================================================
  // Shadow of the vendor fields, snooped from accepted writes
  logic        wr_ok;
  logic        rd_ok;
  logic [2:0]  ctl_q;
  logic [27:0] tmr_q;
  logic [7:0]  tmp_q;
  logic [6:0]  thr_q;
  logic        degr_x;
  logic        fifo_x;
  logic        rec_x;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign rd_ok = psel && penable && pready && !pwrite;
  assign degr_x = degraded_state && (is_media_access || (is_test_unit_ready && !ctl_q[0]));
  assign fifo_x = queue_wait_over && ctl_q[1];
  assign rec_x = recovered_error && post_error_enable && (bits_in_error > thr_q);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_q <= {1'b0, AGING_EN_RST, DEGR_DIS_RST};
      tmr_q <= {EXEC_TIMER_RST, AGING_LIMIT_RST};
      tmp_q <= TEMP_THR_RST;
      thr_q <= RPT_THR_RST;
    end else if (wr_ok) begin
      if (paddr == ADDR_VEND_CTRL) ctl_q <= pwdata[2:0];
      if (paddr == ADDR_VEND_TIMERS) tmr_q <= pwdata[27:0];
      if (paddr == ADDR_VEND_THRESH) tmp_q <= pwdata[7:0];
      // Out-of-range threshold keeps the old value
      if (paddr == ADDR_VEND_THRESH && pwdata[14:8] >= RPT_THR_MIN && pwdata[14:8] <= RPT_THR_MAX)
        thr_q <= pwdata[14:8];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  degr_report_a: assert property ($past(rst_n) |-> report_degraded == $past(degr_x))
    else $error("report_degraded wrong");
  fifo_force_a: assert property ($past(rst_n) |-> fifo_order_force == $past(fifo_x))
    else $error("fifo_order_force wrong");
  recov_report_a: assert property ($past(rst_n) |-> report_recovered == $past(rec_x))
    else $error("report_recovered wrong");
  thermal_default_a: assert property (
    thermal_threshold == ((tmp_q == 8'h00) ? TEMP_THR_DEF : tmp_q))
    else $error("thermal_threshold wrong");
  aging_limit_a: assert property (aging_limit == tmr_q[15:0])
    else $error("aging_limit wrong");
  certify_out_a: assert property (format_certify == ctl_q[2])
    else $error("format_certify wrong");
  abort_pulse_a: assert property (cmd_aborted |-> tmr_q[27:16] != 12'h000 ##1 !cmd_aborted)
    else $error("cmd_aborted wrong");
  density_zero_a: assert property (
    rd_ok && paddr == ADDR_BD_LEN |-> prdata[7:0] == DENSITY_CODE)
    else $error("density code not zero");
endmodule // mpc_mode_checker_asserts
